// ===== dv/tcp_host_model.sv
// host processor model driving the parallel strobe bus
// assumes the bench calls xfer; one access per call
`timescale 1ns/100ps
module tcp_host_model (
   // clock
   input wire       clk_sys,
   // strobes and selects
   output reg       host_chip_select_n,
   output reg       host_read_strobe_n,
   output reg       host_write_strobe_n,
   output reg       cmd_data_select,
   output reg       nibble_select,
   // data bus halves
   output reg [7:0] host_data_in,
   input wire [7:0] host_data_out,
   input wire       host_data_oe
);
   initial begin
      host_chip_select_n  = 1'b1;
      host_read_strobe_n  = 1'b1;
      host_write_strobe_n = 1'b1;
      cmd_data_select     = 1'b0;
      nibble_select       = 1'b0;
      host_data_in        = 8'h00;
   end
   // strobe held six cycles, over the 50 ns minimum width
   task xfer(input c, input n, input r, input w, input [7:0] d,
             output [7:0] q, output qoe);
      begin
         @(posedge clk_sys);
         #1;
         cmd_data_select     = c;
         nibble_select       = n;
         host_data_in        = d;
         host_chip_select_n  = 1'b0;
         host_read_strobe_n  = r;
         host_write_strobe_n = w;
         repeat (6) @(posedge clk_sys);
         #1;
         q   = host_data_out;
         qoe = host_data_oe;
         host_chip_select_n  = 1'b1;
         host_read_strobe_n  = 1'b1;
         host_write_strobe_n = 1'b1;
         // no pull resistors: a released bus must not keep old data
         host_data_in        = ~d;
         repeat (95) @(posedge clk_sys);
      end
   endtask
endmodule

// ===== dv/tcp_host_port_bench.sv
// self-checking bench for the transcoder host command port
// assumes tcp_defs.vh on the include path
`timescale 1ns/100ps
`include "tcp_defs.vh"
module tcp_host_port_bench;
   reg        clk_sys, srst, chip_sleep_n, law_select;
   reg  [3:0] enc_quiet;
   reg  [7:0] rd_val, init_seen;
   reg        rd_oe;
   integer    error_cnt, num_checks, cyc, i;
   wire       cs_n, rd_n, wr_n, cds, nib, oe, rrq_n, mu, run, ssm, nar;
   wire [7:0] din, dout, s_init, s_sleep, s_mute, thl;
   wire [3:0] n_en, q_en;
   wire [2:0] n_lvl;
   localparam [15:0] RW_CMDS = {`TCP_CMD_QUIET_EN, `TCP_CMD_NOISE_EN,
                                `TCP_CMD_MUTE, `TCP_CMD_SLEEP};
   localparam [31:0] WR_PAT  = 32'hffff5aa5;
   localparam [31:0] RB_EXP  = 32'hf00f5aa5;
   tcp_host_model i_tcp_host_model (.clk_sys(clk_sys),
      .host_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .cmd_data_select(cds),
      .nibble_select(nib), .host_data_in(din), .host_data_out(dout),
      .host_data_oe(oe));
   tcp_host_port i_tcp_host_port (.clk_sys(clk_sys), .srst(srst),
      .host_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .cmd_data_select(cds),
      .nibble_select(nib), .host_data_in(din), .host_data_out(dout),
      .host_data_oe(oe), .read_request_n(rrq_n),
      .chip_sleep_n(chip_sleep_n), .law_select(law_select),
      .enc_quiet(enc_quiet), .stream_init(s_init), .stream_sleep(s_sleep),
      .stream_mute(s_mute), .noise_enable(n_en), .noise_level(n_lvl),
      .quiet_enable(q_en), .quiet_threshold_low(thl), .mu_law_mode(mu),
      .clock_run(run), .sync_serial_mode(ssm), .narrow_mode(nar));
   // ------------------------------------------------------------
   // clock, watchdog, tasks
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      init_seen <= init_seen | s_init;
      cyc = cyc + 1;
      if (cyc == 10000) begin
         error_cnt = error_cnt + 1;
         end_sim;
      end
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input string what, input [7:0] exp, input [7:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task cmd(input n, input [3:0] code);
      i_tcp_host_model.xfer(1, n, 1, 0, {4'h0, code}, rd_val, rd_oe);
   endtask
   task dwr(input n, input [7:0] d);
      i_tcp_host_model.xfer(0, n, 1, 0, d, rd_val, rd_oe);
   endtask
   task drd(input n);
      i_tcp_host_model.xfer(0, n, 0, 1, 8'h00, rd_val, rd_oe);
   endtask
   task pins(input s, input l, input [3:0] q);
      begin
         @(posedge clk_sys);
         #1;
         chip_sleep_n = s;
         law_select   = l;
         enc_quiet    = q;
         repeat (6) @(posedge clk_sys);
         #1;
      end
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      init_seen = 8'h00;
      srst = 1'b1;
      chip_sleep_n = 1'b1;
      law_select = 1'b0;
      enc_quiet = 4'h0;
      repeat (12) @(posedge clk_sys);
      #1 srst = 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("rrq", 8'h01, {7'h0, rrq_n});
      for (i = 0; i < 4; i = i + 1) begin
         cmd(0, RW_CMDS[i*4 +: 4]);
         drd(0);
         chk("reset", 8'h00, rd_val);
         dwr(0, WR_PAT[i*8 +: 8]);
         drd(0);
         chk("rdback", RB_EXP[i*8 +: 8], rd_val);
      end
      chk("sleep", 8'ha5, s_sleep);
      chk("mute", 8'h5a, s_mute);
      chk("n_en", 8'h0f, {4'h0, n_en});
      chk("q_en", 8'h0f, {4'h0, q_en});
      cmd(0, `TCP_CMD_SLEEP);
      drd(0);
      chk("reselect", 8'ha5, rd_val);
      chk("rd_oe", 8'h01, {7'h0, rd_oe});
      $display("test registers done");
      cmd(0, `TCP_CMD_NOISE_LVL);
      dwr(0, 8'h05);
      chk("n_lvl", 8'h05, {5'h0, n_lvl});
      cmd(0, `TCP_CMD_QUIET_THL);
      dwr(0, 8'h3c);
      chk("thl", 8'h3c, thl);
      cmd(0, `TCP_CMD_INIT);
      dwr(0, 8'h81);
      chk("init", 8'h81, init_seen);
      chk("init_clr", 8'h00, s_init);
      $display("test write only done");
      cmd(0, `TCP_CMD_QUIET_EN);
      dwr(0, 8'ha0);
      pins(1, 0, 4'h4);
      chk("rrq_off", 8'h01, {7'h0, rrq_n});
      pins(1, 0, 4'h8);
      chk("rrq_on", 8'h00, {7'h0, rrq_n});
      cmd(0, `TCP_CMD_QUIET_FLG);
      dwr(0, 8'hff);
      drd(0);
      chk("flags", 8'h80, rd_val);
      drd(1);
      chk("upper8", 8'h00, {7'h0, rd_oe});
      i_tcp_host_model.xfer(0, 0, 0, 0, 8'h00, rd_val, rd_oe);
      chk("undef", 8'h00, {7'h0, rd_oe | ssm});
      $display("test silence done");
      cmd(1, `TCP_CMD_MUTE);
      chk("narrow", 8'h01, {7'h0, nar});
      dwr(1, 8'h0c);
      dwr(0, 8'h03);
      chk("mute4", 8'hc3, s_mute);
      drd(1);
      chk("hi4", 8'h0c, rd_val);
      drd(0);
      chk("lo4", 8'h03, rd_val);
      cmd(0, `TCP_CMD_MUTE);
      chk("wide", 8'h00, {7'h0, nar});
      $display("test narrow done");
      pins(0, 1, 4'h0);
      chk("mu_run", 8'h02, {6'h0, mu, run});
      pins(1, 0, 4'h0);
      chk("a_run", 8'h01, {6'h0, mu, run});
      i_tcp_host_model.xfer(1, 1, 0, 0, 8'h00, rd_val, rd_oe);
      chk("sync", 8'h01, {6'h0, rd_oe, ssm});
      $display("test pins done");
      end_sim;
   end
endmodule

// ===== dv/tcp_host_port_sva.sv
// pin-level assertions for the transcoder host command port
// assumes it is bound onto tcp_host_port: one clock, sync reset
`timescale 1ns/100ps
module tcp_host_port_sva (
   // clock and reset
   input wire       clk_sys,
   input wire       srst,
   // host side
   input wire       host_chip_select_n,
   input wire       host_read_strobe_n,
   input wire       host_write_strobe_n,
   input wire       cmd_data_select,
   input wire       nibble_select,
   input wire       host_data_oe,
   input wire       read_request_n,
   // pins and cores
   input wire       chip_sleep_n,
   input wire       law_select,
   input wire [3:0] enc_quiet,
   input wire [7:0] stream_init,
   input wire [3:0] quiet_enable,
   input wire       mu_law_mode,
   input wire       clock_run,
   input wire       sync_serial_mode,
   input wire       narrow_mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ------------------------------------------------------------
   // sequences and properties
   // ------------------------------------------------------------
   wire cs_wr  = !host_chip_select_n && !host_write_strobe_n;
   wire cmd_wr = cs_wr && host_read_strobe_n && cmd_data_select;
   wire all_lo = cs_wr && !host_read_strobe_n;
   sequence s_cmd_narrow;
      (cmd_wr && nibble_select)[*5];
   endsequence
   sequence s_cmd_wide;
      (cmd_wr && !nibble_select)[*5];
   endsequence
   property p_narrow;
      s_cmd_narrow |-> ##[0:3] narrow_mode;
   endproperty
   property p_wide;
      s_cmd_wide |-> ##[0:3] !narrow_mode;
   endproperty
   property p_oe_cause;
      host_data_oe |-> !$past(host_chip_select_n, 2) &&
         !$past(host_read_strobe_n, 2) && $past(host_write_strobe_n, 2)
         && !$past(cmd_data_select, 2);
   endproperty
   property p_oe_idle;
      host_chip_select_n [*3] |-> !host_data_oe;
   endproperty
   property p_sync;
      (all_lo && cmd_data_select && nibble_select)[*5]
         |-> ##[0:3] sync_serial_mode && !host_data_oe;
   endproperty
   property p_rdrq;
      ($stable(enc_quiet) && $stable(quiet_enable))[*5]
         |-> read_request_n == !(|(enc_quiet & quiet_enable));
   endproperty
   property p_law;
      $stable(law_select)[*4] |-> mu_law_mode == law_select;
   endproperty
   property p_run;
      $stable(chip_sleep_n)[*4] |-> clock_run == chip_sleep_n;
   endproperty
   property p_init;
      stream_init != 8'h00 |=> stream_init == 8'h00;
   endproperty
   a_narrow: assert property (p_narrow) else $error("no narrow mode");
   a_wide: assert property (p_wide) else $error("no wide mode");
   a_oe_cause: assert property (p_oe_cause) else $error("bad drive");
   a_oe_idle: assert property (p_oe_idle) else $error("idle drive");
   a_sync: assert property (p_sync) else $error("no sync mode");
   a_rdrq: assert property (p_rdrq) else $error("bad request");
   a_law: assert property (p_law) else $error("bad law");
   a_run: assert property (p_run) else $error("bad run");
   a_init: assert property (p_init) else $error("long init");
endmodule

bind tcp_host_port tcp_host_port_sva i_tcp_host_port_sva (
   .clk_sys(clk_sys), .srst(srst),
   .host_chip_select_n(host_chip_select_n),
   .host_read_strobe_n(host_read_strobe_n),
   .host_write_strobe_n(host_write_strobe_n),
   .cmd_data_select(cmd_data_select), .nibble_select(nibble_select),
   .host_data_oe(host_data_oe), .read_request_n(read_request_n),
   .chip_sleep_n(chip_sleep_n), .law_select(law_select),
   .enc_quiet(enc_quiet), .stream_init(stream_init),
   .quiet_enable(quiet_enable), .mu_law_mode(mu_law_mode),
   .clock_run(clock_run), .sync_serial_mode(sync_serial_mode),
   .narrow_mode(narrow_mode));

// ===== hdl/tcp_defs.vh
// constants for the transcoder host command port
// assumes inclusion by plain name from hdl/
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

// ----------------------------------------------------------------
// register numbers (command codes)
// ----------------------------------------------------------------
`define TCP_CMD_NOP        4'h0
`define TCP_CMD_INIT       4'h1
`define TCP_CMD_SLEEP      4'h2
`define TCP_CMD_MUTE       4'h3
`define TCP_CMD_NOISE_EN   4'h4
`define TCP_CMD_NOISE_LVL  4'h5
`define TCP_CMD_QUIET_EN   4'h6
`define TCP_CMD_QUIET_FLG  4'h7
`define TCP_CMD_QUIET_THL  4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCP_RST_BYTE       8'h00
`define TCP_RST_CMD        4'h0
// idle pin levels: sleep pin, chip select and both strobes high
`define TCP_RST_PINS       14'h01e0

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define TCP_HI_MSB         7
`define TCP_HI_LSB         4
`define TCP_LO_MSB         3
`define TCP_LO_LSB         0
`define TCP_NOISE_EN_MASK  8'h0f
`define TCP_NOISE_LVL_MASK 8'h07
`define TCP_QUIET_MASK     8'hf0

// ----------------------------------------------------------------
// host timing (ns) for reference by the bench
// ----------------------------------------------------------------
`define TCP_T_WR_WR_NS     100
`define TCP_T_DW_CW_NS     900
`define TCP_T_CW_RD_NS     100
`define TCP_T_RD_NS        100
`define TCP_CLK_NS         10
`define TCP_T_DW_CW_CYC    ((`TCP_T_DW_CW_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)

`endif

// ===== hdl/tcp_host_port.v
// host command port of a four-channel speech transcoder
// assumes asynchronous host strobes, synchronised here onto clk_sys
//
// Contract
// - command/data select high takes writes as command; low moves data.
// - narrow mode: nibble select high upper half, low lower half.
// - command write with nibble select high enters 4-bit mode.
// - command write with nibble select low enters 8-bit mode.
// - read when select low, read low, write high; device drives bus.
// - write when select low, read high, write low; device captures bus.
// - 8-bit mode data write loads whole byte from bits 7..0.
// - 8-bit mode data read returns whole byte on bits 7..0.
// - all strobes low with both selects high sets synchronous serial mode.
// - undefined strobe combinations do nothing; bus stays released.
// - read request driven low while any enabled encoder is silent.
// - eight encoder/decoder streams run independently and concurrently.
// - law select high picks mu-law, low picks A-law, for all streams.
// - sleep input low stops the oscillator and all clocked activity.
// - pass-through mode uses 8-bit framing instead of 4-bit words.
// - sub-channels A and B share one serial clock per direction.
// - system reset loads every control register with initial value.
// - silence flags are read-only; high when enabled input silent.
`timescale 1ns/100ps
`include "tcp_defs.vh"
module tcp_host_port (
   // clock and reset
   input  wire       clk_sys,
   input  wire       srst,
   // host strobes and selects (asynchronous)
   input  wire       host_chip_select_n,
   input  wire       host_read_strobe_n,
   input  wire       host_write_strobe_n,
   input  wire       cmd_data_select,
   input  wire       nibble_select,
   // host data bus, split three ways
   input  wire [7:0] host_data_in,
   output reg  [7:0] host_data_out,
   output wire       host_data_oe,
   // read request to host
   output wire       read_request_n,
   // chip pins
   input  wire       chip_sleep_n,
   input  wire       law_select,
   // silence from the encoder cores, one per encoder stream
   input  wire [3:0] enc_quiet,
   // control outputs to the speech cores
   output reg  [7:0] stream_init,
   output wire [7:0] stream_sleep,
   output wire [7:0] stream_mute,
   output wire [3:0] noise_enable,
   output wire [2:0] noise_level,
   output wire [3:0] quiet_enable,
   output wire [7:0] quiet_threshold_low,
   output wire       mu_law_mode,
   output wire       clock_run,
   output reg        sync_serial_mode,
   output reg        narrow_mode
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // merge one nibble into a byte at the half named by hi
   function [7:0] nib_merge;
      input [7:0] old;
      input [3:0] nib;
      input       hi;
      begin
         if (hi) begin
            nib_merge = {nib, old[`TCP_LO_MSB:`TCP_LO_LSB]};
         end else begin
            nib_merge = {old[`TCP_HI_MSB:`TCP_HI_LSB], nib};
         end
      end
   endfunction

   // one half of a byte, presented on bits 3..0 of the bus
   function [7:0] nib_pick;
      input [7:0] full;
      input       hi;
      begin
         if (hi) begin
            nib_pick = {4'h0, full[`TCP_HI_MSB:`TCP_HI_LSB]};
         end else begin
            nib_pick = {4'h0, full[`TCP_LO_MSB:`TCP_LO_LSB]};
         end
      end
   endfunction

   // registers the store keeps; nop, init strobes and flags never land
   function reg_writable;
      input [3:0] code;
      begin
         case (code)
            `TCP_CMD_SLEEP,
            `TCP_CMD_MUTE,
            `TCP_CMD_NOISE_EN,
            `TCP_CMD_NOISE_LVL,
            `TCP_CMD_QUIET_EN,
            `TCP_CMD_QUIET_THL: reg_writable = 1'b1;
            default:            reg_writable = 1'b0;
         endcase
      end
   endfunction

   // registers whose stored byte reads back; write-only ones read zero
   function reg_readable;
      input [3:0] code;
      begin
         case (code)
            `TCP_CMD_SLEEP,
            `TCP_CMD_MUTE,
            `TCP_CMD_NOISE_EN,
            `TCP_CMD_QUIET_EN: reg_readable = 1'b1;
            default:           reg_readable = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // synchronisers, two flops for every pin
   // ----------------------------------------------------------------
   reg  [13:0] pin_meta_reg;
   reg  [13:0] pin_sync_reg;
   reg  [7:0]  din_meta_reg;
   reg  [7:0]  din_sync_reg;
   wire [13:0] pin_raw;

   assign pin_raw = {enc_quiet, law_select, chip_sleep_n,
                     host_chip_select_n, host_read_strobe_n,
                     host_write_strobe_n, cmd_data_select,
                     nibble_select, 3'h0};

   // data and strobes share the same two stages, so both arrive together;
   // the host must present data no later than its write strobe
   always @(posedge clk_sys) begin
      if (srst) begin
         pin_meta_reg <= `TCP_RST_PINS;
         pin_sync_reg <= `TCP_RST_PINS;
         din_meta_reg <= `TCP_RST_BYTE;
         din_sync_reg <= `TCP_RST_BYTE;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         din_meta_reg <= host_data_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   wire [3:0] quiet_s  = pin_sync_reg[13:10];
   wire       law_s    = pin_sync_reg[9];
   wire       sleep_ns = pin_sync_reg[8];
   wire       cs_n     = pin_sync_reg[7];
   wire       rd_n     = pin_sync_reg[6];
   wire       wr_n     = pin_sync_reg[5];
   wire       cd_sel   = pin_sync_reg[4];
   wire       nb_sel   = pin_sync_reg[3];

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   wire acc_wr = !cs_n && rd_n && !wr_n;
   wire acc_rd = !cs_n && !rd_n && wr_n && !cd_sel;
   wire acc_sync = !cs_n && !rd_n && !wr_n && cd_sel && nb_sel;
   wire cmd_wr  = acc_wr && cd_sel;
   wire data_wr = acc_wr && !cd_sel;
   // upper-half access in 8-bit mode is inhibited
   wire data_ok = narrow_mode || !nb_sel;

   // a data write lands once, on its first synced cycle, however long held
   reg wr_prev_reg;
   wire wr_pulse = data_wr && !wr_prev_reg;
   reg [3:0] cmd_reg;

   // ----------------------------------------------------------------
   // command capture and bus width
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         cmd_reg          <= `TCP_RST_CMD;
         narrow_mode      <= 1'b0;
         wr_prev_reg      <= 1'b0;
         sync_serial_mode <= 1'b0;
      end else begin
         wr_prev_reg <= data_wr;
         if (cmd_wr) begin
            cmd_reg     <= din_sync_reg[3:0];
            narrow_mode <= nb_sel;
         end
         if (acc_sync) begin
            sync_serial_mode <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // register store
   // ----------------------------------------------------------------
   reg  [7:0] wmask;
   reg  [7:0] wdata;
   reg        wen;
   wire [7:0] rf_q;
   wire [63:0] regs;

   always @* begin
      wdata = din_sync_reg;
      wmask = 8'hff;
      if (narrow_mode) begin
         wdata = nib_merge(8'h00, din_sync_reg[3:0], nb_sel);
         wmask = nb_sel ? 8'hf0 : 8'h0f;
      end
      case (cmd_reg)
         `TCP_CMD_NOISE_EN:  wmask = wmask & `TCP_NOISE_EN_MASK;
         `TCP_CMD_NOISE_LVL: wmask = wmask & `TCP_NOISE_LVL_MASK;
         `TCP_CMD_QUIET_EN:  wmask = wmask & `TCP_QUIET_MASK;
         default:            wmask = wmask;
      endcase
      // flags read-only, init handled as strobes, nop stores nothing
      wen = wr_pulse && data_ok && reg_writable(cmd_reg);
   end

   tcp_regfile u_rf (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .wr_en    (wen),
      .wr_addr  (cmd_reg[2:0]),
      .wr_mask  (wmask),
      .wr_data  (wdata),
      .rd_addr  (cmd_reg[2:0]),
      .rd_data  (rf_q),
      .all_regs (regs)
   );

   // ----------------------------------------------------------------
   // init strobes, one cycle then self clear
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         stream_init <= `TCP_RST_BYTE;
      end else if (wr_pulse && data_ok && cmd_reg == `TCP_CMD_INIT) begin
         stream_init <= wdata & wmask;
      end else begin
         stream_init <= `TCP_RST_BYTE;
      end
   end

   // the threshold register sits at index 0 of the store, remapped
   assign quiet_threshold_low = regs[7:0];
   assign stream_sleep = regs[`TCP_CMD_SLEEP*8 +: 8];
   assign stream_mute  = regs[`TCP_CMD_MUTE*8 +: 8];
   assign noise_enable = regs[`TCP_CMD_NOISE_EN*8 +: 4];
   assign noise_level  = regs[`TCP_CMD_NOISE_LVL*8 +: 3];
   assign quiet_enable = regs[`TCP_CMD_QUIET_EN*8+4 +: 4];

   // ----------------------------------------------------------------
   // silence flags and read request
   // ----------------------------------------------------------------
   wire [3:0] quiet_flags = quiet_s & quiet_enable;
   assign read_request_n = ~|quiet_flags;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   reg [7:0] rd_byte;
   always @* begin
      if (cmd_reg == `TCP_CMD_QUIET_FLG) begin
         rd_byte = {quiet_flags, 4'h0};
      end else if (reg_readable(cmd_reg)) begin
         rd_byte = rf_q;
      end else begin
         rd_byte = `TCP_RST_BYTE;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         host_data_out <= `TCP_RST_BYTE;
      end else if (narrow_mode) begin
         host_data_out <= nib_pick(rd_byte, nb_sel);
      end else begin
         host_data_out <= rd_byte;
      end
   end

   // drive only on a valid read; everything else keeps bus released
   assign host_data_oe = acc_rd && data_ok;

   // ----------------------------------------------------------------
   // chip-level controls
   // ----------------------------------------------------------------
   // clock gating itself is outside; this only requests the stop
   assign clock_run   = sleep_ns;
   assign mu_law_mode = law_s;
   // framing and shared serial clocks live in the cores
endmodule

// ===== hdl/tcp_regfile.v
// eight-byte control register store with registered read data
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
`include "tcp_defs.vh"
module tcp_regfile (
   // clock and reset
   input  wire       clk_sys,
   input  wire       srst,
   // write side
   input  wire       wr_en,
   input  wire [2:0] wr_addr,
   input  wire [7:0] wr_mask,
   input  wire [7:0] wr_data,
   // read side
   input  wire [2:0] rd_addr,
   output reg  [7:0] rd_data,
   // whole contents
   output wire [63:0] all_regs
);
   reg [7:0] mem_reg [0:7];
   integer i;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : flat
         assign all_regs[g*8 +: 8] = mem_reg[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem_reg[i] <= `TCP_RST_BYTE;
         end
         rd_data <= `TCP_RST_BYTE;
      end else begin
         if (wr_en) begin
            mem_reg[wr_addr] <= (mem_reg[wr_addr] & ~wr_mask) |
                                (wr_data & wr_mask);
         end
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule
